/* message_indicator_blink_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// message indicator blink sequencer
module message_indicator_blink_timer #(
  parameter int unsigned CYCLES_PER_MS = blink_timing_pkg::CYC_PER_MS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       blink_wr,
  input  wire logic [7:0] blink_wdata,
  output logic      [7:0] blink_rdata,
  input  wire logic [1:0] ramp_sel,
  input  wire logic [2:0] period_count,
  input  wire logic       indicator_enable,
  output logic            ramp_up,
  output logic            pulse_on,
  output logic            ramp_down,
  output logic            off_hold,
  output logic            blank,
  output logic            active,
  output logic      [2:0] period_index,
  output logic      [6:0] blank_index
);

  localparam int unsigned MW = blink_timing_pkg::MS_W;
  localparam int unsigned BW = blink_timing_pkg::BLANK_CNT_W;

  ms_tick_if tk ();

  ms_tick_gen #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // blink register
  logic [7:0] blink_r;
  logic [7:0] blink_nxt;

  always_comb begin
    blink_nxt = blink_r;
    if (blink_wr) begin
      blink_nxt = blink_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_r <= blink_timing_pkg::BLINK_RESET;
    end else begin
      blink_r <= blink_nxt;
    end
  end

  assign blink_rdata = blink_r;

  // field decode
  logic [3:0]    blank_mult;
  logic [3:0]    pulse_code;
  logic [MW-1:0] pulse_len;
  logic [MW-1:0] ramp_len;
  logic [MW-1:0] period_len;
  logic [BW-1:0] blank_periods;

  assign blank_mult = blink_r[blink_timing_pkg::BLANK_MSB:blink_timing_pkg::BLANK_LSB];
  assign pulse_code = blink_r[blink_timing_pkg::PULSE_MSB:blink_timing_pkg::PULSE_LSB];
  assign pulse_len  = blink_timing_pkg::pulse_ms(pulse_code);
  assign ramp_len   = blink_timing_pkg::ramp_ms(ramp_sel);
  assign period_len = MW'((ramp_len << 1) + (pulse_len << 1));
  assign blank_periods = BW'(period_count) * BW'(blank_mult);

  // sequencer
  blink_timing_pkg::phase_type state_r;
  blink_timing_pkg::phase_type state_nxt;
  logic [MW-1:0] ms_r;
  logic [MW-1:0] ms_nxt;
  logic [2:0]    pcnt_r;
  logic [2:0]    pcnt_nxt;
  logic [BW-1:0] bcnt_r;
  logic [BW-1:0] bcnt_nxt;
  logic [MW-1:0] phase_len;
  logic          phase_done;
  logic          clr;
  logic          last_period;

  always_comb begin
    case (state_r)
      blink_timing_pkg::ST_RAMP_UP: phase_len = ramp_len;
      blink_timing_pkg::ST_RAMP_DN: phase_len = ramp_len;
      blink_timing_pkg::ST_PULSE:   phase_len = pulse_len;
      blink_timing_pkg::ST_OFF:     phase_len = pulse_len;
      blink_timing_pkg::ST_BLANK:   phase_len = period_len;
      default:                      phase_len = '0;
    endcase
  end

  assign phase_done  = (ms_r >= phase_len);
  assign last_period = ({1'b0, pcnt_r} + 4'h1 >= {1'b0, period_count});

  always_comb begin
    state_nxt = state_r;
    pcnt_nxt  = pcnt_r;
    bcnt_nxt  = bcnt_r;
    clr       = 1'b0;
    if (!indicator_enable || period_count == 3'h0) begin
      state_nxt = blink_timing_pkg::ST_IDLE;
      pcnt_nxt  = '0;
      bcnt_nxt  = '0;
      clr       = 1'b1;
    end else begin
      case (state_r)
        blink_timing_pkg::ST_IDLE: begin
          state_nxt = blink_timing_pkg::ST_RAMP_UP;
          pcnt_nxt  = '0;
          clr       = 1'b1;
        end
        blink_timing_pkg::ST_RAMP_UP: begin
          if (phase_done) begin
            state_nxt = blink_timing_pkg::ST_PULSE;
            clr       = 1'b1;
          end
        end
        blink_timing_pkg::ST_PULSE: begin
          if (phase_done) begin
            state_nxt = blink_timing_pkg::ST_RAMP_DN;
            clr       = 1'b1;
          end
        end
        blink_timing_pkg::ST_RAMP_DN: begin
          if (phase_done) begin
            state_nxt = blink_timing_pkg::ST_OFF;
            clr       = 1'b1;
          end
        end
        blink_timing_pkg::ST_OFF: begin
          if (phase_done) begin
            clr = 1'b1;
            if (!last_period) begin
              state_nxt = blink_timing_pkg::ST_RAMP_UP;
              pcnt_nxt  = pcnt_r + 3'h1;
            end else if (blank_periods == '0) begin
              state_nxt = blink_timing_pkg::ST_RAMP_UP;
              pcnt_nxt  = '0;
            end else begin
              state_nxt = blink_timing_pkg::ST_BLANK;
              pcnt_nxt  = '0;
              bcnt_nxt  = '0;
            end
          end
        end
        blink_timing_pkg::ST_BLANK: begin
          if (phase_done) begin
            clr = 1'b1;
            if (bcnt_r + 1'b1 >= blank_periods) begin
              state_nxt = blink_timing_pkg::ST_RAMP_UP;
              bcnt_nxt  = '0;
            end else begin
              bcnt_nxt  = bcnt_r + 1'b1;
            end
          end
        end
        default: begin
          state_nxt = blink_timing_pkg::ST_IDLE;
          clr       = 1'b1;
        end
      endcase
    end
  end

  assign tk.clr = clr;

  // active flag kept in its own flop, in step with the state register
  logic active_r;
  logic active_nxt;

  always_comb begin
    active_nxt = |state_nxt[4:1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  always_comb begin
    if (clr) begin
      ms_nxt = '0;
    end else if (tk.tick && ms_r != {MW{1'b1}}) begin
      ms_nxt = ms_r + 1'b1;
    end else begin
      ms_nxt = ms_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= blink_timing_pkg::ST_IDLE;
      ms_r    <= '0;
      pcnt_r  <= '0;
      bcnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      ms_r    <= ms_nxt;
      pcnt_r  <= pcnt_nxt;
      bcnt_r  <= bcnt_nxt;
    end
  end

  assign ramp_up      = state_r[1];
  assign pulse_on     = state_r[2];
  assign ramp_down    = state_r[3];
  assign off_hold     = state_r[4];
  assign blank        = state_r[5];
  assign active       = active_r;
  assign period_index = pcnt_r;
  assign blank_index  = bcnt_r;

endmodule : message_indicator_blink_timer
`default_nettype wire

/* blink_timing_pkg.sv */
// Function
// - period is two ramps plus two pulses
// - active time is period times period count
// - blank time is active time times multiplier
// - blank multiplier in bits 7:4, default 0
// - ramp code selects 78/156/312/624 ms
// - period count 0..7, default 0
`default_nettype none
package blink_timing_pkg;

  // clock and millisecond base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W    = 18;

  // register layout and reset values
  localparam int unsigned BLANK_MSB     = 7;
  localparam int unsigned BLANK_LSB     = 4;
  localparam int unsigned PULSE_MSB     = 3;
  localparam int unsigned PULSE_LSB     = 0;
  localparam logic [7:0]  BLINK_RESET   = 8'h00;
  localparam logic [1:0]  RAMP_DEFAULT  = 2'h0;
  localparam logic [2:0]  PERIODS_DEF   = 3'h0;

  // millisecond counter and blank period counter widths
  localparam int unsigned MS_W          = 12;
  localparam int unsigned BLANK_CNT_W   = 7;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RAMP_UP = 6'h02,
    ST_PULSE   = 6'h04,
    ST_RAMP_DN = 6'h08,
    ST_OFF     = 6'h10,
    ST_BLANK   = 6'h20
  } phase_type;

  // pulse time per code, in ms
  function automatic logic [MS_W-1:0] pulse_ms(input logic [3:0] code);
    case (code)
      4'h0:    pulse_ms = 12'h000;
      4'h1:    pulse_ms = 12'h020;
      4'h2:    pulse_ms = 12'h040;
      4'h3:    pulse_ms = 12'h05C;
      4'h4:    pulse_ms = 12'h080;
      4'h5:    pulse_ms = 12'h0A0;
      4'h6:    pulse_ms = 12'h0C4;
      4'h7:    pulse_ms = 12'h0E0;
      4'h8:    pulse_ms = 12'h100;
      4'h9:    pulse_ms = 12'h120;
      4'hA:    pulse_ms = 12'h140;
      4'hB:    pulse_ms = 12'h160;
      4'hC:    pulse_ms = 12'h180;
      4'hD:    pulse_ms = 12'h1A0;
      4'hE:    pulse_ms = 12'h1C0;
      default: pulse_ms = 12'h1E0;
    endcase
  endfunction : pulse_ms

  // ramp time per code, in ms
  function automatic logic [MS_W-1:0] ramp_ms(input logic [1:0] code);
    case (code)
      2'h0:    ramp_ms = 12'h04E;
      2'h1:    ramp_ms = 12'h09C;
      2'h2:    ramp_ms = 12'h138;
      default: ramp_ms = 12'h270;
    endcase
  endfunction : ramp_ms

endpackage : blink_timing_pkg
`default_nettype wire

/* ms_tick_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ms_tick_if;
  logic clr;
  logic tick;
  modport gen  (input clr, output tick);
  modport user (output clr, input tick);
endinterface : ms_tick_if
`default_nettype wire

/* ms_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none
// millisecond prescaler, restarted by clr
module ms_tick_gen #(
  parameter int unsigned CYCLES_PER_MS = blink_timing_pkg::CYC_PER_MS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  ms_tick_if.gen    tk
);

  logic [blink_timing_pkg::PRESCALE_W-1:0] cnt_r;
  logic [blink_timing_pkg::PRESCALE_W-1:0] cnt_nxt;
  logic                                    wrap;

  assign wrap    = (cnt_r == blink_timing_pkg::PRESCALE_W'(CYCLES_PER_MS - 1));
  assign tk.tick = wrap && !tk.clr;

  always_comb begin
    if (tk.clr || wrap) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : ms_tick_gen
`default_nettype wire

/* blink_timer_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module blink_timer_assertions #(
  parameter int unsigned CYCLES_PER_MS = 1
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       blink_wr,
  input wire logic [7:0] blink_wdata,
  input wire logic [7:0] blink_rdata,
  input wire logic [2:0] period_count,
  input wire logic       indicator_enable,
  input wire logic       ramp_up,
  input wire logic       pulse_on,
  input wire logic       ramp_down,
  input wire logic       off_hold,
  input wire logic       blank,
  input wire logic       active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_write_readback: assert property (
    blink_wr |=> blink_rdata == $past(blink_wdata)) else $error("readback wrong");
  a_active_flag: assert property (
    active == (ramp_up | pulse_on | ramp_down | off_hold)) else $error("active wrong");
  a_phase_onehot: assert property (
    $onehot0({ramp_up, pulse_on, ramp_down, off_hold, blank})) else $error("two phases");
  a_start_ramp: assert property (
    !active && !blank && indicator_enable && period_count != 3'h0 |=> ramp_up)
    else $error("no start");
  a_stop_idle: assert property (
    !indicator_enable || period_count == 3'h0 |=> !active && !blank) else $error("no stop");
  a_up_then_pulse: assert property (
    ramp_up ##1 (!ramp_up && active) |-> pulse_on) else $error("order after ramp up");
  a_pulse_then_down: assert property (
    pulse_on ##1 (!pulse_on && active) |-> ramp_down) else $error("order after pulse");
  a_blank_entry: assert property (
    $rose(blank) |-> $past(off_hold)) else $error("blank not after period");
  a_active_gate: assert property (
    active |-> $past(indicator_enable) && $past(period_count) != 3'h0)
    else $error("active while stopped");
  a_down_then_off: assert property (
    ramp_down ##1 (!ramp_down && active) |-> off_hold) else $error("order after ramp down");
endmodule : blink_timer_assertions
bind message_indicator_blink_timer blink_timer_assertions #(
  .CYCLES_PER_MS(CYCLES_PER_MS)) blink_timer_assertions_i (.*);
`default_nettype wire

/* message_indicator_blink_timer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module message_indicator_blink_timer_tb;
  localparam int CPM = 1;
  logic       clk, rst_n, blink_wr, indicator_enable;
  logic [7:0] blink_wdata, blink_rdata;
  logic [1:0] ramp_sel;
  logic [2:0] period_count, period_index;
  logic [6:0] blank_index;
  logic       ramp_up, pulse_on, ramp_down, off_hold, blank, active;
  int         err_count, tests_run, cyc, seed;
  int pt[16] = '{0, 32, 64, 92, 128, 160, 196, 224, 256, 288, 320, 352, 384, 416, 448, 480};
  int rt[4] = '{78, 156, 312, 624};
  message_indicator_blink_timer #(.CYCLES_PER_MS(CPM)) message_indicator_blink_timer_i (.*);
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    blink_wr <= 1'b1;
    blink_wdata <= d;
    @(posedge clk);
    blink_wr <= 1'b0;
    @(negedge clk);
    check("rdata", blink_rdata, d);
  endtask : wr
  // measures one phase that is high now, leaves at the next phase
  task automatic phase(input int b, input int exp);
    logic [4:0] v;
    int n;
    n = 0;
    v = {blank, off_hold, ramp_down, pulse_on, ramp_up};
    while (v[b] === 1'b1 && n < 40000) begin
      n++;
      @(negedge clk);
      v = {blank, off_hold, ramp_down, pulse_on, ramp_up};
    end
    check("phase length", n, exp);
  endtask : phase
  task automatic run(input int c, m, p, r);
    int l;
    int q[$];
    l = 2 * rt[r] + 2 * pt[p];
    q = '{rt[r] * CPM + 1, pt[p] * CPM + 1, rt[r] * CPM + 1, pt[p] * CPM + 1};
    wr({m[3:0], p[3:0]});
    @(posedge clk);
    ramp_sel <= r[1:0];
    period_count <= c[2:0];
    indicator_enable <= 1'b1;
    for (int w = 0; w < 4 && ramp_up !== 1'b1; w++) @(negedge clk);
    for (int k = 0; k < c; k++) begin
      check("period index", period_index, k);
      phase(0, q[0]);
      phase(1, q[1]);
      phase(2, q[2]);
      phase(3, q[3]);
    end
    if (c * m > 0) begin
      check("blank entry", blank & (blank_index == 7'h00), 1);
      repeat (l * CPM + 1) @(negedge clk);
      check("blank index", blank_index, (c * m > 1) ? 1 : 0);
      phase(4, (c * m - 1) * (l * CPM + 1));
    end
    check("restart", ramp_up, 1);
    @(posedge clk);
    indicator_enable <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    check("idle", active | blank, 0);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    seed = 32'h0000_bda3;
    {rst_n, blink_wr, indicator_enable, blink_wdata, ramp_sel, period_count} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("reset rdata", blink_rdata, 8'h00);
    for (int p = 0; p < 16; p++) run(1, 0, p, 0);
    for (int r = 0; r < 4; r++) run(r + 1, r, $random(seed) & 15, r);
    @(posedge clk);
    period_count <= 3'h0;
    indicator_enable <= 1'b1;
    repeat (3) @(negedge clk);
    check("count zero idle", active | blank, 0);
    @(posedge clk);
    indicator_enable <= 1'b0;
    stop_test();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      stop_test();
    end
  end
endmodule : message_indicator_blink_timer_tb
`default_nettype wire
